// ### design/slpi_pkg.sv
// Package with register map, field positions and reset values for the setup length, polarity and enable bank.
package slpi_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] RD_LEN_LOW = 8'hD6;
  localparam logic [7:0] RD_LEN_HIGH = 8'hD7;
  localparam logic [7:0] RD_POLARITY = 8'hDA;
  localparam logic [7:0] WR_POLARITY = 8'h5A;
  localparam logic [7:0] RD_IRQ_ENABLE = 8'hDB;
  localparam logic [7:0] WR_IRQ_ENABLE = 8'h5B;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int POL_IRQ_BIT = 0;
  localparam int POL_DMA_REQUEST_PIN_BIT = 1;
  localparam int POL_DMA_ACKNOWLEDGE_PIN_BIT = 2;
  localparam logic [7:0] POL_WRITE_MASK = 8'h07;
  localparam logic [7:0] LEN_RESET = 8'h00;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h01;
  localparam int SRC_SETUP_READY = 0;
  localparam int SRC_BULK_ONE = 1;
  localparam int SRC_BULK_TWO = 2;
  localparam int SRC_CTRL_RX = 3;
  localparam int SRC_CTRL_TX = 4;
  localparam int SRC_BUS_RESET = 5;
  localparam int SRC_SUSPEND = 6;
  localparam int SRC_IRQ_EP_THREE = 7;
  // ----------------------------------------
  // Bus access states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SLPI_IDLE = 2'b00,
    SLPI_READ = 2'b01,
    SLPI_WRITE = 2'b10
  } slpi_acc_t;
endpackage

// ### design/slpi_pin_polarity.sv
// Polarity adapter that turns internal active-high levels into pin levels and back.
`timescale 1ns/100ps
module slpi_pin_polarity (
  // Internal levels
  input wire logic irq_level,
  input wire logic dma_request_pin_level,
  output logic dma_acknowledge_pin_level,
  // Polarity settings
  input wire logic [2:0] pol_bits,
  // Pin levels
  output logic irq_pin_level,
  output logic dma_request_pin_pin_level,
  input wire logic dma_acknowledge_pin
);
  // Polarity 0 means active low for both requests, but active high for acknowledge.
  always_comb begin
    irq_pin_level = pol_bits[slpi_pkg::POL_IRQ_BIT] ? irq_level : ~irq_level;
    dma_request_pin_pin_level = pol_bits[slpi_pkg::POL_DMA_REQUEST_PIN_BIT] ? dma_request_pin_level : ~dma_request_pin_level;
    dma_acknowledge_pin_level = pol_bits[slpi_pkg::POL_DMA_ACKNOWLEDGE_PIN_BIT] ? ~dma_acknowledge_pin : dma_acknowledge_pin;
  end
endmodule

// ### design/slpi_reg_bank.sv
// Register bank slice: setup length capture, pin polarity select and interrupt source enable.
`timescale 1ns/100ps
// ----------------------------------------
// Overview of operation
// - The request length of every setup packet is captured by hardware with no software action, except in a cycle with a bus reset, which wins.
// - The low length byte reads at D6h, cannot be written, and is zero after hardware or bus reset.
// - The high length byte reads at D7h, cannot be written, and is zero after hardware or bus reset.
// - The polarity register reads at DAh, writes at 5Ah, returns its setting and is zero after hardware reset.
// - Request outputs are active low at polarity 0 and high at 1, acknowledge is active high at 0 and low at 1.
// - Polarity bits 7 to 3 always read zero and written ones there are dropped.
// - The interrupt enable register reads at DBh and writes at 5Bh with one bit per source.
// - Enables reset to 01h on hardware reset and are kept across a bus reset.
// - Only sources with their enable set may raise an interrupt.
// - Enable rewrites are accepted at any time and take effect on the status one cycle later.
// - Each enable bit gates the status bit at the same position.
// - Enable bits are setup, bulk one, bulk two, control rx, control tx, bus reset, suspend, endpoint three.
// - A status bit reads zero while disabled, else follows its event, and any set bit asserts the request pin.
// ----------------------------------------
module slpi_reg_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Microcontroller bus, strobes active low, one write per strobe, a read every cycle the read strobe is held
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rdata_oe,
  // Setup capture from the serial engine
  input wire logic setup_valid,
  input wire logic [15:0] setup_length,
  input wire logic usb_bus_reset,
  // Raw interrupt events and DMA request
  input wire logic [7:0] irq_events,
  input wire logic dma_request_level,
  // Status and pins
  output logic [7:0] irq_cause_status,
  output logic dma_ack_level,
  output logic irq_request_pin,
  output logic dma_request_pin,
  input wire logic dma_acknowledge_pin
);
  typedef struct packed {
    logic [7:0] len_low_r;
    logic [7:0] len_high_r;
    logic [2:0] pol_r;
    logic [7:0] enable_r;
    logic [7:0] status_r;
    logic [7:0] rdata_r;
    logic rdata_oe_r;
    logic irq_pin_r;
    logic dma_request_pin_pin_r;
    logic dma_acknowledge_pin_r;
    slpi_pkg::slpi_acc_t acc_r;
  } slpi_state_t;

  slpi_state_t st_r;
  slpi_state_t st_nxt;
  logic irq_pin_level;
  logic dma_request_pin_pin_level;
  logic dma_acknowledge_pin_level;
  logic [7:0] gated_status;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  function automatic logic [7:0] read_value(input logic [7:0] a, input slpi_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      slpi_pkg::RD_LEN_LOW: v = s.len_low_r;
      slpi_pkg::RD_LEN_HIGH: v = s.len_high_r;
      slpi_pkg::RD_POLARITY: v = {5'h00, s.pol_r};
      slpi_pkg::RD_IRQ_ENABLE: v = s.enable_r;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Status follows events one cycle later under the current mask, so a rewrite takes effect next cycle.
  assign gated_status = irq_events & st_r.enable_r;

  slpi_pin_polarity slpi_pin_polarity_i (
    .irq_level(|st_r.status_r),
    .dma_request_pin_level(dma_request_level),
    .dma_acknowledge_pin_level(dma_acknowledge_pin_level),
    .pol_bits(st_r.pol_r),
    .irq_pin_level(irq_pin_level),
    .dma_request_pin_pin_level(dma_request_pin_pin_level),
    .dma_acknowledge_pin(dma_acknowledge_pin)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.status_r = gated_status;
    st_nxt.irq_pin_r = irq_pin_level;
    st_nxt.dma_request_pin_pin_r = dma_request_pin_pin_level;
    st_nxt.dma_acknowledge_pin_r = dma_acknowledge_pin_level;
    st_nxt.rdata_oe_r = 1'b0;
    case (st_r.acc_r)
      slpi_pkg::SLPI_IDLE: begin
        if (!cs_n && !rd_n) begin
          st_nxt.acc_r = slpi_pkg::SLPI_READ;
        end else if (!cs_n && !wr_n) begin
          st_nxt.acc_r = slpi_pkg::SLPI_WRITE;
          // Writes act once per strobe, on its leading edge.
          if (addr == slpi_pkg::WR_POLARITY) begin
            st_nxt.pol_r = wdata[2:0] & slpi_pkg::POL_WRITE_MASK[2:0];
          end
          if (addr == slpi_pkg::WR_IRQ_ENABLE) begin
            st_nxt.enable_r = wdata;
          end
        end
      end
      slpi_pkg::SLPI_READ: begin
        if (cs_n || rd_n) begin
          st_nxt.acc_r = slpi_pkg::SLPI_IDLE;
        end
      end
      slpi_pkg::SLPI_WRITE: begin
        if (cs_n || wr_n) begin
          st_nxt.acc_r = slpi_pkg::SLPI_IDLE;
        end
      end
      default: st_nxt.acc_r = slpi_pkg::SLPI_IDLE;
    endcase
    if (!cs_n && !rd_n) begin
      st_nxt.rdata_r = read_value(addr, st_r);
      st_nxt.rdata_oe_r = 1'b1;
    end
    // Bus reset clears only the length bytes; polarity and enables are kept.
    if (usb_bus_reset) begin
      st_nxt.len_low_r = slpi_pkg::LEN_RESET;
      st_nxt.len_high_r = slpi_pkg::LEN_RESET;
    end else if (setup_valid) begin
      st_nxt.len_low_r = setup_length[7:0];
      st_nxt.len_high_r = setup_length[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.len_low_r <= slpi_pkg::LEN_RESET;
      st_r.len_high_r <= slpi_pkg::LEN_RESET;
      st_r.pol_r <= slpi_pkg::POL_RESET[2:0];
      st_r.enable_r <= slpi_pkg::IRQ_ENABLE_RESET;
      st_r.status_r <= 8'h00;
      st_r.rdata_r <= 8'h00;
      st_r.rdata_oe_r <= 1'b0;
      st_r.irq_pin_r <= 1'b1;
      st_r.dma_request_pin_pin_r <= 1'b1;
      st_r.dma_acknowledge_pin_r <= 1'b0;
      st_r.acc_r <= slpi_pkg::SLPI_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output comes straight from a flip-flop, so the acknowledge level trails its pin by one cycle.
  assign rdata = st_r.rdata_r;
  assign rdata_oe = st_r.rdata_oe_r;
  assign irq_cause_status = st_r.status_r;
  assign irq_request_pin = st_r.irq_pin_r;
  assign dma_request_pin = st_r.dma_request_pin_pin_r;
  assign dma_ack_level = st_r.dma_acknowledge_pin_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  length_pair_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (setup_valid && !usb_bus_reset) |=> ({st_r.len_high_r, st_r.len_low_r} == $past(setup_length)))
    else $error("Length bytes not captured together.");
  length_busrst_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    usb_bus_reset |=> (st_r.len_low_r == 8'h00 && st_r.len_high_r == 8'h00))
    else $error("Length bytes not cleared by bus reset.");
  length_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!setup_valid && !usb_bus_reset) |=> $stable({st_r.len_high_r, st_r.len_low_r}))
    else $error("Length bytes changed without a setup packet.");
  pol_upper_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (rdata_oe && $past(addr) == slpi_pkg::RD_POLARITY) |-> rdata[7:3] == 5'h00)
    else $error("Polarity upper bits read nonzero.");
  pol_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r.acc_r == slpi_pkg::SLPI_IDLE && !cs_n && rd_n && !wr_n && addr == slpi_pkg::WR_POLARITY
     && !usb_bus_reset) |=> st_r.pol_r == $past(wdata[2:0]))
    else $error("Polarity write not stored.");
  enable_keep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (usb_bus_reset && (cs_n || wr_n)) |=> $stable(st_r.enable_r))
    else $error("Enables changed on bus reset.");
  status_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> irq_cause_status == ($past(irq_events) & $past(st_r.enable_r)))
    else $error("Status not gated by enables.");
  irq_pin_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> irq_request_pin == ($past(st_r.pol_r[0]) ? $past(|st_r.status_r) : !$past(|st_r.status_r)))
    else $error("Interrupt pin polarity wrong.");
  dma_request_pin_pin_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> dma_request_pin == ($past(st_r.pol_r[1]) ^ !$past(dma_request_level)))
    else $error("DMA request pin polarity wrong.");
  dma_acknowledge_pin_level_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> dma_ack_level == ($past(st_r.pol_r[2]) ^ $past(dma_acknowledge_pin)))
    else $error("DMA acknowledge level polarity wrong.");
  enable_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r.acc_r == slpi_pkg::SLPI_IDLE && !cs_n && rd_n && !wr_n && addr == slpi_pkg::WR_IRQ_ENABLE)
    |=> st_r.enable_r == $past(wdata))
    else $error("Enable write not stored.");
  enable_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cs_n && !rd_n && addr == slpi_pkg::RD_IRQ_ENABLE) |=> (rdata_oe && rdata == $past(st_r.enable_r)))
    else $error("Enable read returned wrong data.");
  len_low_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cs_n && !rd_n && addr == slpi_pkg::RD_LEN_LOW) |=> (rdata_oe && rdata == $past(st_r.len_low_r)))
    else $error("Low length read returned wrong data.");
  len_high_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!cs_n && !rd_n && addr == slpi_pkg::RD_LEN_HIGH) |=> (rdata_oe && rdata == $past(st_r.len_high_r)))
    else $error("High length read returned wrong data.");
  write_once_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (st_r.acc_r == slpi_pkg::SLPI_WRITE) |=> ($stable(st_r.pol_r) && $stable(st_r.enable_r)))
    else $error("Held write strobe wrote twice.");
  pol_keep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (usb_bus_reset && (cs_n || wr_n)) |=> $stable(st_r.pol_r))
    else $error("Polarity changed on bus reset.");
endmodule

// ### verif/slpi_mcu_model.sv
// Microcontroller bus model that issues register reads and writes to the bank.
`timescale 1ns/100ps
module slpi_mcu_model (
  // Clock
  input wire logic ref_clk,
  // Bus to the bank
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rdata_oe
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // Callers enter just after a rising edge; a released bus shows an inverted address, and after a write inverted data, not stale ones.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    wdata = d;
    @(posedge ref_clk);
    #10;
    cs_n = 1'b1;
    wr_n = 1'b1;
    addr = ~a;
    wdata = ~d;
    @(posedge ref_clk);
    #10;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge ref_clk);
      #10;
      if (rdata_oe === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end
    end
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a;
    @(posedge ref_clk);
    #10;
  endtask
endmodule

// ### verif/slpi_reg_bank_bench.sv
// Self-checking bench for the setup length, polarity and enable register bank.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module slpi_reg_bank_bench;
  logic ref_clk = 1'b0, arst_n = 1'b0, cs_n, rd_n, wr_n, rdata_oe, setup_valid = 1'b0, usb_bus_reset = 1'b0;
  logic dma_request_level = 1'b0, dma_ack_level, irq_request_pin, dma_request_pin, dma_acknowledge_pin = 1'b0;
  logic [7:0] addr, wdata, rdata, irq_cause_status, m, irq_events = 8'h00;
  logic [15:0] setup_length = 16'h0000;
  int fails = 0, tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  slpi_mcu_model slpi_mcu_model_i (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe));
  slpi_reg_bank slpi_reg_bank_i (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe), .setup_valid(setup_valid),
    .setup_length(setup_length), .usb_bus_reset(usb_bus_reset), .irq_events(irq_events),
    .dma_request_level(dma_request_level), .irq_cause_status(irq_cause_status), .dma_ack_level(dma_ack_level),
    .irq_request_pin(irq_request_pin), .dma_request_pin(dma_request_pin), .dma_acknowledge_pin(dma_acknowledge_pin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A read that never answers is fatal to the run, since later checks would all be skewed.
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    slpi_mcu_model_i.rd(a, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      close_out();
    end else begin
      `CHK(d, e)
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc(slpi_pkg::RD_LEN_LOW, slpi_pkg::LEN_RESET);
    rdc(slpi_pkg::RD_LEN_HIGH, slpi_pkg::LEN_RESET);
    rdc(slpi_pkg::RD_POLARITY, slpi_pkg::POL_RESET);
    rdc(slpi_pkg::RD_IRQ_ENABLE, slpi_pkg::IRQ_ENABLE_RESET);
    `CHK(irq_request_pin, 1'b1)
    $display("t_reset done");
  endtask
  task automatic t_setup();
    setup_length = 16'h1234;
    setup_valid = 1'b1;
    tick(1);
    setup_valid = 1'b0;
    slpi_mcu_model_i.wr(8'h56, 8'hFF);
    rdc(slpi_pkg::RD_LEN_LOW, 8'h34);
    rdc(slpi_pkg::RD_LEN_HIGH, 8'h12);
    rdc(8'hD8, 8'h00);
    slpi_mcu_model_i.wr(slpi_pkg::WR_POLARITY, 8'hFD);
    slpi_mcu_model_i.wr(slpi_pkg::WR_IRQ_ENABLE, 8'hC3);
    setup_length = 16'hABCD;
    setup_valid = 1'b1;
    usb_bus_reset = 1'b1;
    tick(1);
    setup_valid = 1'b0;
    usb_bus_reset = 1'b0;
    rdc(slpi_pkg::RD_LEN_LOW, 8'h00);
    rdc(slpi_pkg::RD_LEN_HIGH, 8'h00);
    rdc(slpi_pkg::RD_POLARITY, 8'h05);
    rdc(slpi_pkg::RD_IRQ_ENABLE, 8'hC3);
    $display("t_setup done");
  endtask
  task automatic t_pins();
    dma_request_level = 1'b1;
    tick(2);
    `CHK({irq_request_pin, dma_request_pin, dma_ack_level}, 3'b001)
    dma_acknowledge_pin = 1'b1;
    slpi_mcu_model_i.wr(slpi_pkg::WR_POLARITY, 8'h02);
    tick(1);
    `CHK({irq_request_pin, dma_request_pin, dma_ack_level}, 3'b111)
    dma_request_level = 1'b0;
    $display("t_pins done");
  endtask
  task automatic t_mask();
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      slpi_mcu_model_i.wr(slpi_pkg::WR_IRQ_ENABLE, m);
      irq_events = ~m;
      tick(2);
      `CHK({irq_cause_status, irq_request_pin}, {8'h00, 1'b1})
      irq_events = 8'hFF;
      tick(2);
      `CHK({irq_cause_status, irq_request_pin}, {m, 1'b0})
    end
    slpi_mcu_model_i.wr(slpi_pkg::WR_IRQ_ENABLE, 8'h00);
    `CHK(irq_cause_status, 8'h00)
    $display("t_mask done");
  endtask
  task automatic t_hw_reset();
    slpi_mcu_model_i.wr(slpi_pkg::WR_POLARITY, 8'h07);
    slpi_mcu_model_i.wr(slpi_pkg::WR_IRQ_ENABLE, 8'hFF);
    rdc(slpi_pkg::RD_POLARITY, 8'h07);
    `CHK(rdata_oe, 1'b0)
    irq_events = 8'h00;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(1);
    t_reset();
    $display("t_hw_reset done");
  endtask
  initial begin
    tick(6);
    arst_n = 1'b1;
    tick(1);
    t_reset();
    t_setup();
    t_pins();
    t_mask();
    t_hw_reset();
    close_out();
  end
endmodule
